// ### bench/ncs_pack_model.sv
// ncs_pack_model.sv - cell pack, thermistor and supply seen through comparators
// assumes the bench sets pack voltage, temperature and sense current as plain numbers
`timescale 1ns/1ps

module ncs_pack_model (
	input  wire logic                supply_ok_i, // supply above operating level
	input  wire logic signed [15:0]  cell_mv_i,   // per-cell voltage, mV
	input  wire logic signed [15:0]  temp_c_i,    // pack temperature, C
	input  wire logic signed [15:0]  cur_mv_i,    // sense drop, positive = reverse
	input  wire logic                slope_i,     // pack heating fast
	input  wire logic                mode_i,      // high = comparator mode
	output ncs_pkg::ncs_sense_t      sense_o      // comparator results
);
	import ncs_pkg::*;

	// ==================================================================
	// comparator thresholds
	// ==================================================================
	// every result follows the pack at once; the design must synchronise
	always_comb begin
		sense_o.supply_lockout  = !supply_ok_i;
		sense_o.above_open      = cell_mv_i > 16'sd1650;
		sense_o.below_insert    = cell_mv_i < 16'sd1550;
		sense_o.above_low_batt  = cell_mv_i > 16'sd1000;
		sense_o.temp_in_range   = temp_c_i > 0 && temp_c_i < 16'sd45;
		sense_o.temp_over       = temp_c_i > 16'sd50;
		sense_o.slope_trip      = slope_i;
		sense_o.discharge_set   = cur_mv_i >= 16'sd10;
		sense_o.discharge_clear = cur_mv_i <= -16'sd10;
		sense_o.mode_comparator = mode_i;
	end

endmodule : ncs_pack_model

// ### bench/nimh_charge_state_machine_test.sv
// nimh_charge_state_machine_test.sv - self-checking bench of the charge sequencer
// assumes the tick is shortened to 4 cycles so all sequence times stay short
`timescale 1ns/1ps
`include "ncs_defines.svh"

module nimh_charge_state_machine_test;
	import ncs_pkg::*;

	// one step: pack condition, settle time, expected outputs, lamp-on count in 64
	typedef struct {
		int mv; int tc; int cur; logic md; int wt;
		logic [7:0] st; logic [1:0] lv; logic [7:0] tg; logic oe; logic dq; int lamp;
	} ncs_row_t;

	// ==================================================================
	// signals
	// ==================================================================
	logic                      clock_i = 1'b0;  // 25 MHz
	logic                      rst_i;           // async reset
	logic                      supply_ok;       // supply state
	logic                      slope;           // heating flag
	logic                      mode;            // regulation mode
	logic signed [15:0]        cell_mv;         // pack voltage
	logic signed [15:0]        temp_c;          // pack temperature
	logic signed [15:0]        cur_mv;          // sense drop
	logic [`NCS_TIMER_W-1:0]   fc_count;        // fast-charge length
	ncs_sense_t                sense;           // comparator results
	logic [1:0]                reg_level_o;
	logic [7:0]                reg_target_o;
	logic                      charge_drive_out_o;
	logic                      charge_drive_oe_o;
	logic                      status_lamp_o;
	logic                      status_lamp_oe_o;
	logic [7:0]                state_o;
	int                        n_fail = 0;      // mismatches
	int                        checks = 0;      // comparisons
	int                        cyc = 0;         // run length
	int                        n;               // measured cycles
	ncs_row_t                  rows [16];       // ordinary steps

	// ==================================================================
	// instances
	// ==================================================================
	ncs_pack_model u_ncs_pack_model (.supply_ok_i(supply_ok), .cell_mv_i(cell_mv),
		.temp_c_i(temp_c), .cur_mv_i(cur_mv), .slope_i(slope), .mode_i(mode), .sense_o(sense));

	ncs_charger #(.TICK_CYCLES(4)) u_ncs_charger (.clock_i(clock_i), .rst_i(rst_i),
		.sense_i(sense), .fc_count_i(fc_count), .reg_level_o(reg_level_o),
		.reg_target_o(reg_target_o), .charge_drive_out_o(charge_drive_out_o),
		.charge_drive_oe_o(charge_drive_oe_o), .status_lamp_o(status_lamp_o),
		.status_lamp_oe_o(status_lamp_oe_o), .state_o(state_o));

	// clock, half period 20 ns
	always #20 clock_i = ~clock_i;

	// hang guard, well above the expected run of about 70000 cycles
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			n_fail++;
			give_verdict();
		end
	end

	// ==================================================================
	// tasks
	// ==================================================================
	// closing report
	task automatic give_verdict;
		if (n_fail == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	// compare seen against expected
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// count lamp-on cycles over 64, a whole number of both blink periods
	task automatic lamp_cnt(output int k);
		k = 0;
		repeat (64) begin
			@(negedge clock_i);
			if (status_lamp_oe_o === 1'b1) begin
				k++;
				chk("lamp level", status_lamp_o, 0);
			end
		end
	endtask : lamp_cnt

	// cycles until state_o shows s, bounded
	task automatic wait_st(input logic [7:0] s, input int lim, output int k);
		k = 0;
		while (state_o !== s && k < lim) begin
			@(negedge clock_i);
			k++;
		end
		chk("state reached", state_o, s);
	endtask : wait_st

	// new pack condition, applied on a falling edge
	task automatic pack(input int mv, input int tc, input int cur);
		cell_mv = 16'(mv);
		temp_c  = 16'(tc);
		cur_mv  = 16'(cur);
	endtask : pack

	// ==================================================================
	// main sequence
	// ==================================================================
	initial begin
		rows = '{
			'{1700, 25,   0, 0, 300, 8'h02, 2'h0, 8'h00, 0, 0,  0},
			'{ 900, 25,   0, 0,  20, 8'h04, 2'h1, 8'hDF, 1, 1, 32},
			'{ 900, 25,   0, 1,   8, 8'h04, 2'h1, 8'hE3, 1, 1, 32},
			'{1200, 25,   0, 1, 200, 8'h08, 2'h2, 8'h95, 1, 1, 32},
			'{1200, 25,   0, 0,   8, 8'h08, 2'h2, 8'h87, 1, 1, 32},
			'{1700, 25,   0, 0,  20, 8'h02, 2'h0, 8'h00, 0, 0,  0},
			'{1200, 25,   0, 0, 200, 8'h08, 2'h2, 8'h87, 1, 1, 32},
			'{1200, 55,   0, 0,  20, 8'h20, 2'h0, 8'h00, 0, 0, 64},
			'{1700, 25,   0, 0,  20, 8'h02, 2'h0, 8'h00, 0, 0,  0},
			'{ 900, 25,   0, 0,  20, 8'h04, 2'h1, 8'hDF, 1, 1, 32},
			'{ 900, 55,   0, 0,  20, 8'h40, 2'h0, 8'h00, 0, 0, 32},
			'{1700, 25,   0, 0,  20, 8'h02, 2'h0, 8'h00, 0, 0,  0},
			'{ 900, 25,   0, 0,  20, 8'h04, 2'h1, 8'hDF, 1, 1, 32},
			'{ 900, 25,  12, 0,  20, 8'h80, 2'h0, 8'h00, 1, 0,  0},
			'{1700, 55,   0, 0,  20, 8'h80, 2'h0, 8'h00, 1, 0,  0},
			'{1700, 25, -12, 0,  20, 8'h02, 2'h0, 8'h00, 0, 0,  0}
		};
		rst_i = 1'b1;
		supply_ok = 1'b1;
		slope = 1'b0;
		mode = 1'b0;
		// long fast timer so the table rows never time out of fast charge
		fc_count = `NCS_TIMER_W'(1000);
		pack(1700, 25, 0);
		repeat (12) @(negedge clock_i);
		chk("reset state", state_o, 8'h01);
		rst_i = 1'b0;
		// ordinary steps
		foreach (rows[i]) begin
			pack(rows[i].mv, rows[i].tc, rows[i].cur);
			mode = rows[i].md;
			repeat (rows[i].wt) @(negedge clock_i);
			chk("state", state_o, rows[i].st);
			chk("level", reg_level_o, rows[i].lv);
			chk("target", reg_target_o, rows[i].tg);
			chk("drive oe", charge_drive_oe_o, rows[i].oe);
			chk("drive value", charge_drive_out_o, rows[i].dq);
			lamp_cnt(n);
			chk("lamp count", n, rows[i].lamp);
		end
		// insertion filter, then fast timer and half-length top-off
		fc_count = `NCS_TIMER_W'(40);
		pack(1200, 25, 0);
		wait_st(8'h04, 20, n);
		wait_st(8'h08, 400, n);
		chk("filter time", n >= 124 && n <= 136, 1);
		wait_st(8'h10, 400, n);
		chk("fast time", n >= 152 && n <= 166, 1);
		chk("top target", reg_target_o, `NCS_TGT_LOW_LIN);
		wait_st(8'h20, 400, n);
		chk("top time", n >= 72 && n <= 86, 1);
		pack(1700, 25, 0);
		wait_st(8'h02, 20, n);
		// slope trip held from the start of fast charge is blanked
		fc_count = `NCS_TIMER_W'(3000);
		slope = 1'b1;
		pack(1200, 25, 0);
		wait_st(8'h08, 400, n);
		wait_st(8'h10, 9000, n);
		chk("blank time", n >= 8245 && n <= 8262, 1);
		pack(1200, 55, 0);
		wait_st(8'h20, 10, n);
		chk("top over temp", n <= 6, 1);
		slope = 1'b0;
		pack(1700, 25, 0);
		wait_st(8'h02, 20, n);
		// lockout glitch, real lockout, restart with pack fitted
		pack(900, 25, 0);
		wait_st(8'h04, 20, n);
		supply_ok = 1'b0;
		repeat (100) @(negedge clock_i);
		supply_ok = 1'b1;
		repeat (200) @(negedge clock_i);
		chk("glitch ignored", state_o, 8'h04);
		supply_ok = 1'b0;
		wait_st(8'h01, 400, n);
		chk("lockout time", n >= 248 && n <= 262, 1);
		chk("lockout drive", charge_drive_oe_o, 0);
		supply_ok = 1'b1;
		wait_st(8'h04, 400, n);
		chk("restart time", n <= 270, 1);
		// pre-charge timeout
		wait_st(8'h40, 60000, n);
		chk("pre timeout", n >= 57590 && n <= 57606, 1);
		give_verdict();
	end

endmodule : nimh_charge_state_machine_test

// ### hdl/ncs_charger.sv
// ncs_charger.sv - charge-cycle sequencer for a series stack of NiMH cells
// assumes comparator results arrive asynchronously on sense_i and that the
// timing-resistor converter delivers the fast-charge length in 8 Hz ticks
`timescale 1ns/1ps
`include "ncs_defines.svh"

// How it works
// - cycle starts at power-up or on insertion
// - lockout forces reset and clears timers
// - lockout deglitched for about 10 us
// - lockout release moves reset to presence
// - presence waits for insertion and 0-45 C
// - four second filter on cell voltage
// - pre-charge uses low regulation target
// - cell above 1.0 V goes fast charge
// - 30 minute timeout or 50 C faults
// - open cell in pre/fast returns presence
// - fast charge uses high regulation target
// - temperature slope trip enters top-off
// - slope ignored first 4.3 minutes
// - fast timer expiry enters top-off
// - over 50 C in fast goes done
// - top-off low level, half timer restart
// - top-off timer or 50 C gives done
// - done: drive released, lamp steady on
// - fault: drive released, lamp blinks
// - done/fault held until pack removed
// - reverse current enters discharge, drive low
// - forward current leaves discharge to presence
// - charging lamp blinks 1 Hz, half duty
// - fault 4 Hz blink; else lamp off
module ncs_charger #(
	parameter int unsigned TICK_CYCLES = `NCS_TICK_CYC  // clock cycles per 8 Hz tick
) (
	input  wire logic                      clock_i,          // 25 MHz core clock
	input  wire logic                      rst_i,            // async reset, active high
	input  wire ncs_pkg::ncs_sense_t       sense_i,          // raw comparator results
	input  wire logic [`NCS_TIMER_W-1:0]   fc_count_i,       // fast-charge length in ticks
	output logic [1:0]                     reg_level_o,      // regulation level select
	output logic [7:0]                     reg_target_o,     // target across sense resistor, mV
	output logic                           charge_drive_out_o, // drive value (1 regulates)
	output logic                           charge_drive_oe_o,  // drive enable
	output logic                           status_lamp_o,    // lamp level when driven
	output logic                           status_lamp_oe_o, // lamp pull-down enable
	output logic [7:0]                     state_o           // current sequencer state
);
	import ncs_pkg::*;

	// ==================================================================
	// input synchroniser
	// ==================================================================
	ncs_sense_t sync_a;  // first stage, read only by sn
	ncs_sense_t sn;      // second stage, used by all logic

	// two flops on every comparator result
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sync_a <= '0;
			sn     <= '0;
		end else begin
			sync_a <= sense_i;
			sn     <= sync_a;
		end
	end

	// ==================================================================
	// lockout deglitch
	// ==================================================================
	logic                    lockout_q;       // filtered lockout
	logic [`NCS_DGCNT_W-1:0] dg_cnt;          // cycles the raw level has differed
	logic                    next_lockout_q;
	logic [`NCS_DGCNT_W-1:0] next_dg_cnt;

	// a change must stand for the whole deglitch time before it is taken
	always_comb begin
		next_lockout_q = lockout_q;
		next_dg_cnt    = '0;
		if (sn.supply_lockout != lockout_q) begin
			if (dg_cnt == `NCS_DGCNT_W'(`NCS_DEGLITCH_CYC - 1)) begin
				next_lockout_q = sn.supply_lockout;
			end else begin
				next_dg_cnt = dg_cnt + `NCS_DGCNT_W'(1);
			end
		end
	end

	// register the deglitch state; lockout held active out of reset
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			lockout_q <= 1'b1;
			dg_cnt    <= '0;
		end else begin
			lockout_q <= next_lockout_q;
			dg_cnt    <= next_dg_cnt;
		end
	end

	// ==================================================================
	// 8 Hz tick and blink phase
	// ==================================================================
	logic [`NCS_TICKCNT_W-1:0] tick_cnt;   // cycles within a tick
	logic                      tick;       // one-cycle enable at 8 Hz
	logic [2:0]                blink;      // bit0 gives 4 Hz, bit2 gives 1 Hz
	logic [`NCS_TICKCNT_W-1:0] next_tick_cnt;
	logic                      next_tick;
	logic [2:0]                next_blink;

	// divider wraps every TICK_CYCLES; blink advances once per tick
	always_comb begin
		next_tick     = 1'b0;
		next_tick_cnt = tick_cnt + `NCS_TICKCNT_W'(1);
		if (tick_cnt == `NCS_TICKCNT_W'(TICK_CYCLES - 1)) begin
			next_tick_cnt = '0;
			next_tick     = 1'b1;
		end
		next_blink = tick ? blink + 3'h1 : blink;
	end

	// register the divider
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
			blink    <= 3'h0;
		end else begin
			tick_cnt <= next_tick_cnt;
			tick     <= next_tick;
			blink    <= next_blink;
		end
	end

	// ==================================================================
	// charge timer, restarted on every state change
	// ==================================================================
	ncs_state_t              state;        // current state
	ncs_state_t              next_state;
	logic [`NCS_TIMER_W-1:0] timer;        // ticks spent in this state
	logic [`NCS_TIMER_W-1:0] next_timer;
	logic                    filt_done;    // insertion filter has elapsed
	logic                    blank_done;   // slope blanking has elapsed
	logic                    pre_expired;  // pre-charge limit reached
	logic                    fc_expired;   // fast-charge limit reached
	logic                    top_expired;  // top-off limit reached

	// limit compares against the running timer
	always_comb begin
		filt_done   = timer >= `NCS_TIMER_W'(`NCS_FILTER_TICKS);
		blank_done  = timer >= `NCS_TIMER_W'(`NCS_BLANK_TICKS);
		pre_expired = timer >= `NCS_TIMER_W'(`NCS_PRE_TICKS);
		fc_expired  = timer >= fc_count_i;
		top_expired = timer >= (fc_count_i >> 1);
	end

	// clear on lockout or state change, else count ticks and saturate
	always_comb begin
		next_timer = timer;
		if (lockout_q || next_state != state) begin
			next_timer = '0;
		end else if (tick && timer != '1) begin
			next_timer = timer + `NCS_TIMER_W'(1);
		end
	end

	// register the timer
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			timer <= '0;
		end else begin
			timer <= next_timer;
		end
	end

	// ==================================================================
	// sequencer
	// ==================================================================
	// lockout wins over everything, reverse current over the rest except in reset
	always_comb begin
		next_state = state;
		if (lockout_q) begin
			next_state = ST_RESET;
		end else if (sn.discharge_set && state != ST_RESET && state != ST_DISCH) begin
			next_state = ST_DISCH;
		end else begin
			unique case (state)
				// lockout released: look for a pack
				ST_RESET: begin
					next_state = ST_PRESENCE;
				end
				// pack fitted at power-up or inserted later
				ST_PRESENCE: begin
					if (sn.below_insert && sn.temp_in_range) begin
						next_state = ST_PRE;
					end
				end
				// reduced-rate conditioning
				ST_PRE: begin
					if (sn.temp_over) begin
						next_state = ST_FAULT;
					end else if (filt_done && sn.above_open) begin
						next_state = ST_PRESENCE;
					end else if (filt_done && sn.above_low_batt) begin
						next_state = ST_FAST;
					end else if (pre_expired) begin
						next_state = ST_FAULT;
					end
				end
				// full-rate charge
				ST_FAST: begin
					if (sn.above_open) begin
						next_state = ST_PRESENCE;
					end else if (sn.temp_over) begin
						next_state = ST_DONE;
					end else if (blank_done && sn.slope_trip) begin
						next_state = ST_TOP;
					end else if (fc_expired) begin
						next_state = ST_TOP;
					end
				end
				// finishing charge on half the timer
				ST_TOP: begin
					if (top_expired || sn.temp_over) begin
						next_state = ST_DONE;
					end
				end
				// held until the pack is taken out
				ST_DONE, ST_FAULT: begin
					if (sn.above_open) begin
						next_state = ST_PRESENCE;
					end
				end
				// pack feeding a load
				ST_DISCH: begin
					if (sn.discharge_clear) begin
						next_state = ST_PRESENCE;
					end
				end
				// illegal code: restart cleanly
				default: begin
					next_state = ST_RESET;
				end
			endcase
		end
	end

	// register the state
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ==================================================================
	// outputs, all registered from the current state
	// ==================================================================
	logic [1:0] next_level;
	logic [7:0] next_target;
	logic       next_drive_out;
	logic       next_drive_oe;
	logic       next_lamp_oe;

	// per-state regulation, drive and lamp pattern
	always_comb begin
		next_level     = LVL_OFF;
		next_target    = `NCS_TGT_OFF;
		next_drive_out = 1'b0;
		next_drive_oe  = 1'b0;
		next_lamp_oe   = 1'b0;
		unique case (state)
			// low level while conditioning or topping off
			ST_PRE, ST_TOP: begin
				next_level     = LVL_LOW;
				next_target    = sn.mode_comparator ? `NCS_TGT_LOW_CMP : `NCS_TGT_LOW_LIN;
				next_drive_out = 1'b1;
				next_drive_oe  = 1'b1;
				next_lamp_oe   = blink[2];
			end
			// high level during fast charge
			ST_FAST: begin
				next_level     = LVL_HIGH;
				next_target    = sn.mode_comparator ? `NCS_TGT_HIGH_CMP : `NCS_TGT_HIGH_LIN;
				next_drive_out = 1'b1;
				next_drive_oe  = 1'b1;
				next_lamp_oe   = blink[2];
			end
			// drive released, lamp steady on
			ST_DONE: begin
				next_lamp_oe = 1'b1;
			end
			// drive released, fast blink
			ST_FAULT: begin
				next_lamp_oe = blink[0];
			end
			// pass element driven fully on, lamp off
			ST_DISCH: begin
				next_drive_oe = 1'b1;
			end
			// reset and presence: everything released
			default: begin
				next_level = LVL_OFF;
			end
		endcase
	end

	// output flops
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			reg_level_o        <= LVL_OFF;
			reg_target_o       <= `NCS_TGT_OFF;
			charge_drive_out_o <= 1'b0;
			charge_drive_oe_o  <= 1'b0;
			status_lamp_o      <= 1'b0;
			status_lamp_oe_o   <= 1'b0;
			state_o            <= ST_RESET;
		end else begin
			reg_level_o        <= next_level;
			reg_target_o       <= next_target;
			charge_drive_out_o <= next_drive_out;
			charge_drive_oe_o  <= next_drive_oe;
			status_lamp_o      <= 1'b0;
			status_lamp_oe_o   <= next_lamp_oe;
			state_o            <= state;
		end
	end

	// ==================================================================
	// assertions
	// ==================================================================
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	AST_LOCKOUT_RESET: assert property (
		lockout_q |=> (state == ST_RESET) && (timer == '0))
		else $error("lockout did not force reset");
	AST_RESET_TO_PRESENCE: assert property (
		(state == ST_RESET) && !lockout_q |=> (state == ST_PRESENCE))
		else $error("reset did not move to presence");
	AST_PRE_LEVEL: assert property (
		(state == ST_PRE) |=> (reg_level_o == LVL_LOW) && charge_drive_oe_o)
		else $error("pre-charge level wrong");
	AST_FAST_TARGET: assert property (
		(state == ST_FAST) |=> reg_target_o ==
			($past(sn.mode_comparator) ? `NCS_TGT_HIGH_CMP : `NCS_TGT_HIGH_LIN))
		else $error("fast-charge target wrong");
	AST_BLANK: assert property (
		(state == ST_FAST) && !blank_done && !fc_expired |=> (state != ST_TOP))
		else $error("slope acted inside blanking");
	AST_DONE_OUT: assert property (
		(state == ST_DONE) |=> status_lamp_oe_o && !charge_drive_oe_o)
		else $error("done outputs wrong");
	AST_FAULT_BLINK: assert property (
		(state == ST_FAULT) |=> !charge_drive_oe_o && (status_lamp_oe_o == $past(blink[0])))
		else $error("fault outputs wrong");
	AST_DISCH_OUT: assert property (
		(state == ST_DISCH) |=> charge_drive_oe_o && !charge_drive_out_o && !status_lamp_oe_o)
		else $error("discharge outputs wrong");
	AST_REMOVAL: assert property (
		(state == ST_DONE || state == ST_FAULT) && sn.above_open && !lockout_q
			&& !sn.discharge_set |=> (state == ST_PRESENCE))
		else $error("removal not seen in done or fault");
	AST_PRE_FILTER: assert property (
		(state == ST_PRE) && !filt_done && !sn.temp_over && !lockout_q
			&& !sn.discharge_set |=> (state == ST_PRE))
		else $error("pre-charge left inside filter");

endmodule : ncs_charger

// ### hdl/ncs_defines.svh
// ncs_defines.svh - clock, timing counts, widths and regulation targets of the charge sequencer
// assumes a 25 MHz core clock; every count below is derived from its own time unit
`ifndef NCS_DEFINES_SVH
`define NCS_DEFINES_SVH

// ==================================================================
// clock and base tick
// ==================================================================
`define NCS_CLK_HZ          25000000
`define NCS_CLK_MHZ         25
`define NCS_TICK_HZ         8
`define NCS_TICK_CYC        (`NCS_CLK_HZ / `NCS_TICK_HZ)

// ==================================================================
// lockout deglitch, about 10 us, rounded up to whole cycles
// ==================================================================
`define NCS_DEGLITCH_NS     10000
`define NCS_DEGLITCH_CYC    ((`NCS_DEGLITCH_NS * `NCS_CLK_MHZ + 999) / 1000)

// ==================================================================
// sequence times, counted in base ticks
// ==================================================================
`define NCS_FILTER_S        4
`define NCS_FILTER_TICKS    (`NCS_FILTER_S * `NCS_TICK_HZ)
`define NCS_PRE_MIN         30
`define NCS_PRE_TICKS       (`NCS_PRE_MIN * 60 * `NCS_TICK_HZ)
`define NCS_BLANK_MIN_X10   43
`define NCS_BLANK_TICKS     ((`NCS_BLANK_MIN_X10 * 60 * `NCS_TICK_HZ) / 10)

// ==================================================================
// widths
// ==================================================================
`define NCS_TIMER_W         18
`define NCS_TICKCNT_W       22
`define NCS_DGCNT_W         8

// ==================================================================
// regulation targets across the sense resistor, two's complement mV
// ==================================================================
`define NCS_TGT_OFF         8'h00
`define NCS_TGT_HIGH_LIN    8'h87
`define NCS_TGT_HIGH_CMP    8'h95
`define NCS_TGT_LOW_LIN     8'hDF
`define NCS_TGT_LOW_CMP     8'hE3

`endif

// ### hdl/ncs_pkg.sv
// ncs_pkg.sv - types shared by the charge sequencer and its bench
// assumes ncs_defines.svh holds all numeric constants
package ncs_pkg;

	// ==================================================================
	// sequencer states, one-hot
	// ==================================================================
	typedef enum logic [7:0] {
		ST_RESET    = 8'h01,
		ST_PRESENCE = 8'h02,
		ST_PRE      = 8'h04,
		ST_FAST     = 8'h08,
		ST_TOP      = 8'h10,
		ST_DONE     = 8'h20,
		ST_FAULT    = 8'h40,
		ST_DISCH    = 8'h80
	} ncs_state_t;

	// regulation level selected for the current amplifier
	typedef enum logic [1:0] {
		LVL_OFF  = 2'h0,
		LVL_LOW  = 2'h1,
		LVL_HIGH = 2'h2
	} ncs_level_t;

	// ==================================================================
	// comparator results arriving from the analog front end
	// ==================================================================
	typedef struct packed {
		logic supply_lockout;   // supply below operating level
		logic above_open;       // cell sense above 1.65 V
		logic below_insert;     // cell sense below cell_insert_threshold
		logic above_low_batt;   // cell sense above low_battery_threshold
		logic temp_in_range;    // thermistor between 0 and 45 C
		logic temp_over;        // thermistor above 50 C
		logic slope_trip;       // temperature slope above 0.5 C per minute
		logic discharge_set;    // reverse current at discharge_set_threshold
		logic discharge_clear;  // forward current at discharge_clear_threshold
		logic mode_comparator;  // high for comparator mode, low for linear
	} ncs_sense_t;

endpackage : ncs_pkg
